// ===== rtl/period_timer.v
/*
 * Top of the 8-bit period timer: APB slave with count, control, limit,
 * interrupt flag and enable registers, and the counting core.
 * Assumes an APB master on clk; data outputs stay synchronous to clk.
 */
// What this block does
// - Count climbs to limit, then wraps zero
// - Limit register read/write, resets to FF
// - Count read/write, cleared by reset
// - Prescale divides by 1, 4 or 16
// - Postscaler divides matches by field plus one
// - Postscaler pulse sets flag bit one
// - Count or control write clears scalers
// - Control write keeps count unchanged
// - Run bit two enables counting
// - Control layout post, run, prescale; bit7 zero
// - Raw match offered to serial port
// - Match usable as PWM time base
`include "period_timer_defs.vh"

module period_timer (
  input  wire        clk,        // System clock, 50 MHz
  input  wire        rst_b,      // Async reset, active low
  input  wire        psel,       // APB select
  input  wire        penable,    // APB enable
  input  wire        pwrite,     // APB direction
  input  wire [11:0] paddr,      // APB byte address
  input  wire [31:0] pwdata,     // APB write data
  input  wire [3:0]  pstrb,      // APB byte strobes
  output wire        pready,     // APB ready
  output reg  [31:0] prdata,     // APB read data
  output wire        pslverr,    // APB error, unmapped address
  output wire        irq,        // Level interrupt
  output wire        sspShift,   // Match pulse to serial port
  output wire        pwmBase,    // Match pulse to PWM unit
  output wire [7:0]  pwmCount    // Count for PWM comparison
);

  // Decode table entries, one per register
  localparam integer FLAGS_AT = 0;
  localparam integer COUNT_AT = 1;
  localparam integer CTL_AT   = 2;
  localparam integer EN_AT    = 3;
  localparam integer LIMIT_AT = 4;
  localparam integer N_REGS   = 5;
  localparam [39:0]  REG_IDX  = {`IDX_LIMIT, `IDX_IRQ_ENABLES, `IDX_CONTROL, `IDX_COUNT,
                                 `IDX_IRQ_FLAGS};

  // Software-visible state and next values
  reg  [7:0]  ctl_q;
  reg  [7:0]  ctl_d;
  reg  [7:0]  limit_q;
  reg  [7:0]  limit_d;
  reg  [7:0]  flags_q;
  wire [7:0]  flags_d;
  reg  [7:0]  enables_q;
  reg  [7:0]  enables_d;
  reg  [31:0] rdata_d;
  reg  [7:0]  rdByte;

  // Bus decode
  wire [9:0]  idx;
  wire        access;
  wire        rdSetup;
  wire        wrEn;
  wire        lane0;
  wire [7:0]  wrByte;
  wire [4:0]  hit;
  wire [4:0]  wrHit;
  wire        mapped;
  wire        countWr;
  wire        ctlWr;
  wire        flagsWr;
  wire        enWr;
  wire        limitWr;

  // Counting core and event flags
  wire [7:0]  count;
  wire        matchPulse;
  wire        postPulse;
  wire        run;
  wire [1:0]  preSel;
  wire [3:0]  postSel;
  wire [7:0]  flagEvent;
  wire [7:0]  flagClear;
  wire [7:0]  pending;

  assign idx     = paddr[11:2];
  assign access  = psel & penable;
  // Read data is captured in the setup cycle, so the access cycle needs no wait
  assign rdSetup = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  // Registers are eight bits wide, so only the low lane carries data
  assign lane0   = pstrb[0];
  assign wrByte  = pwdata[7:0];
  assign wrEn    = access & pwrite & lane0;

  genvar r;
  generate
    for (r = 0; r < N_REGS; r = r + 1) begin : g_dec
      assign hit[r]   = (idx == {2'h0, REG_IDX[8*r +: 8]});
      assign wrHit[r] = wrEn & hit[r];
    end
  endgenerate

  // Unmapped accesses answer with an error and change nothing
  assign mapped  = |hit;
  assign pslverr = access & ~mapped;
  assign countWr = wrHit[COUNT_AT];
  assign ctlWr   = wrHit[CTL_AT];
  assign flagsWr = wrHit[FLAGS_AT];
  assign enWr    = wrHit[EN_AT];
  assign limitWr = wrHit[LIMIT_AT];

  always @* begin
    ctl_d = ctl_q;
    if (ctlWr) begin
      ctl_d = wrByte & `CTL_WMASK;
    end
  end

  always @* begin
    limit_d = limit_q;
    if (limitWr) begin
      limit_d = wrByte;
    end
  end

  always @* begin
    enables_d = enables_q;
    if (enWr) begin
      enables_d = wrByte;
    end
  end

  // Only the match flag has a hardware source; the other bits stay clear
  assign flagEvent = postPulse ? (8'h01 << `IRQ_MATCH_BIT) : 8'h00;
  assign flagClear = flagsWr ? wrByte : 8'h00;

  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_flag
      // Set beats clear so an event during the clearing write is not lost
      assign flags_d[b] = flagEvent[b] | (flags_q[b] & ~flagClear[b]);
    end
  endgenerate

  always @* begin
    case (idx)
      {2'h0, `IDX_IRQ_FLAGS}:   rdByte = flags_q;
      {2'h0, `IDX_COUNT}:       rdByte = count;
      {2'h0, `IDX_CONTROL}:     rdByte = ctl_q;
      {2'h0, `IDX_IRQ_ENABLES}: rdByte = enables_q;
      {2'h0, `IDX_LIMIT}:       rdByte = limit_q;
      default:                  rdByte = 8'h00;
    endcase
  end

  // Read word holds until the next read setup
  always @* begin
    rdata_d = prdata;
    if (rdSetup) begin
      rdata_d = {24'h000000, rdByte};
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q     <= `RST_CONTROL;
      limit_q   <= `RST_LIMIT;
      flags_q   <= `RST_IRQ;
      enables_q <= `RST_IRQ;
      prdata    <= 32'h00000000;
    end else begin
      ctl_q     <= ctl_d;
      limit_q   <= limit_d;
      flags_q   <= flags_d;
      enables_q <= enables_d;
      prdata    <= rdata_d;
    end
  end

  assign pending = flags_q & enables_q;
  assign irq     = |pending;

  assign run     = ctl_q[`CTL_RUN_BIT];
  assign preSel  = ctl_q[`CTL_PRE_MSB:`CTL_PRE_LSB];
  assign postSel = ctl_q[`CTL_POST_MSB:`CTL_POST_LSB];

  period_timer_core u_core (
    .clk         (clk),
    .rst_b       (rst_b),
    .run         (run),
    .preSel      (preSel),
    .postSel     (postSel),
    .periodLimit (limit_q),
    .countWr     (countWr),
    .ctlWr       (ctlWr),
    .wrData      (wrByte),
    .count_q     (count),
    .matchPulse  (matchPulse),
    .postPulse   (postPulse)
  );

  assign sspShift = matchPulse;
  assign pwmBase  = matchPulse;
  assign pwmCount = count;

endmodule

// ===== rtl/period_timer_core.v
/*
 * Counting core: instruction-clock divider, prescaler, 8-bit count with
 * period match, postscaler.
 * Assumes register writes arrive as one-cycle strobes from the register file.
 */
`include "period_timer_defs.vh"

module period_timer_core (
  input  wire       clk,          // System clock
  input  wire       rst_b,        // Async reset, active low
  input  wire       run,          // Counting enable
  input  wire [1:0] preSel,       // Prescale select
  input  wire [3:0] postSel,      // Postscale select
  input  wire [7:0] periodLimit,  // Period limit value
  input  wire       countWr,      // Write strobe to count
  input  wire       ctlWr,        // Write strobe to control
  input  wire [7:0] wrData,       // Write data
  output reg  [7:0] count_q,      // Current count
  output reg        matchPulse,   // Match, before postscaler
  output reg        postPulse     // Postscaler output
);

  reg  [1:0] insnDiv_q;
  reg  [3:0] pre_q;
  reg  [3:0] post_q;
  reg  [3:0] preLast;
  wire       insnTick;
  wire       incTick;
  wire       atLimit;
  wire       scalerClr;

  assign insnTick  = (insnDiv_q == `INSN_DIV);
  assign scalerClr = countWr | ctlWr;
  assign atLimit   = (count_q == periodLimit);

  always @* begin
    case (preSel)
      2'h0:    preLast = `PRE_DIV1_LAST;
      2'h1:    preLast = `PRE_DIV4_LAST;
      default: preLast = `PRE_DIV16_LAST;
    endcase
  end

  assign incTick = run & insnTick & (pre_q == preLast) & ~scalerClr;

  // Free-running divider so the timer steps at the instruction rate
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      insnDiv_q <= 2'h0;
    end else begin
      insnDiv_q <= insnDiv_q + 2'h1;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_q <= 4'h0;
    end else if (scalerClr) begin
      pre_q <= 4'h0;
    end else if (run && insnTick) begin
      pre_q <= (pre_q == preLast) ? 4'h0 : pre_q + 4'h1;
    end
  end

  // A count write wins over an increment in the same cycle; control writes keep count
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q    <= `RST_COUNT;
      matchPulse <= 1'b0;
    end else begin
      matchPulse <= 1'b0;
      if (countWr) begin
        count_q <= wrData;
      end else if (incTick) begin
        if (atLimit) begin
          count_q    <= 8'h00;
          matchPulse <= 1'b1;
        end else begin
          count_q <= count_q + 8'h01;
        end
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      post_q    <= 4'h0;
      postPulse <= 1'b0;
    end else begin
      postPulse <= 1'b0;
      if (scalerClr) begin
        post_q <= 4'h0;
      end else if (matchPulse) begin
        if (post_q == postSel) begin
          post_q    <= 4'h0;
          postPulse <= 1'b1;
        end else begin
          post_q <= post_q + 4'h1;
        end
      end
    end
  end

endmodule

// ===== rtl/period_timer_defs.vh
/*
 * Constants for the 8-bit period timer: register indices, field positions,
 * reset values and scaler codes.
 * Assumes inclusion by bare name from the timer design files.
 */
`ifndef PERIOD_TIMER_DEFS_VH
`define PERIOD_TIMER_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_IRQ_FLAGS     8'h0c
`define IDX_COUNT         8'h11
`define IDX_CONTROL       8'h12
`define IDX_IRQ_ENABLES   8'h8c
`define IDX_LIMIT         8'h92

// Control register fields
`define CTL_PRE_LSB       0
`define CTL_PRE_MSB       1
`define CTL_RUN_BIT       2
`define CTL_POST_LSB      3
`define CTL_POST_MSB      6
`define CTL_WMASK         8'h7f

// Interrupt flag position
`define IRQ_MATCH_BIT     1

// Reset values
`define RST_COUNT         8'h00
`define RST_CONTROL       8'h00
`define RST_LIMIT         8'hff
`define RST_IRQ           8'h00

// Instruction clock is the system clock divided by this plus one
`define INSN_DIV          2'h3

// Prescale terminal counts (divide minus one)
`define PRE_DIV1_LAST     4'h0
`define PRE_DIV4_LAST     4'h3
`define PRE_DIV16_LAST    4'hf

`endif

// ===== tb/period_timer_properties.sv
/* Checker for the period timer top: count, pulse and read-data timing.
   Assumes a bind onto the timer top; sees its ports only. */
module period_timer_properties (
  input logic        clk,      // Clock
  input logic        rst_b,    // Reset, low
  input logic        psel,     // Select
  input logic        penable,  // Enable
  input logic        pwrite,   // Direction
  input logic [11:0] paddr,    // Address
  input logic [31:0] prdata,   // Read data
  input logic        irq,      // Interrupt
  input logic        sspShift, // Match
  input logic        pwmBase,  // Match copy
  input logic [7:0]  pwmCount  // Count
);
  logic [1:0] wrHist_q;
  wire        wrSeen = |wrHist_q;
  // Two deep, in case the count port lags the register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) wrHist_q <= 2'h0;
    else wrHist_q <= {wrHist_q[0], psel & penable & pwrite};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_wrap;
    pwmBase && !wrSeen |-> pwmCount == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("match without zero count");
  property p_step;
    $changed(pwmCount) && !wrSeen |-> pwmCount - $past(pwmCount) == 8'h01 || pwmCount == 8'h00;
  endproperty
  a_step: assert property (p_step) else $error("count jumped");
  property p_gap;
    $changed(pwmCount) && !wrSeen |=> (!$changed(pwmCount) || wrSeen) [*3];
  endproperty
  a_gap: assert property (p_gap) else $error("count faster than tick");
  property p_pulse;
    sspShift |=> !sspShift;
  endproperty
  a_pulse: assert property (p_pulse) else $error("match pulse too long");
  property p_same;
    sspShift == pwmBase;
  endproperty
  a_same: assert property (p_same) else $error("match copies differ");
  property p_flag;
    $rose(irq) && !wrSeen |-> $past(sspShift) || $past(sspShift, 2) || $past(sspShift, 3);
  endproperty
  a_flag: assert property (p_flag) else $error("irq without match");
  property p_bit7;
    psel && penable && !pwrite && paddr == 12'h048 |-> !prdata[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("control bit7 set");
  property p_high;
    psel && penable && !pwrite |-> prdata[31:8] == 24'h000000;
  endproperty
  a_high: assert property (p_high) else $error("read upper bits set");
endmodule

// ===== tb/period_timer_tb.sv
/* Bench for the period timer over APB: registers, period, scalers, irq.
   Assumes the design and checker files are compiled alongside. */
module period_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] FLG = 12'h030, CNT = 12'h044, CTL = 12'h048;
  localparam logic [11:0] ENA = 12'h230, LIM = 12'h248;
  logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rdv;
  logic [3:0]  pstrb = 4'hf;
  logic        errv;
  wire         pready, pslverr, irq, sspShift, pwmBase;
  wire  [31:0] prdata;
  wire  [7:0]  pwmCount;
  int          n_errors = 0, n_tests = 0, k;
  always #10 clk = ~clk;
  period_timer u_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .irq, .sspShift, .pwmBase, .pwmCount);
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next call never reassigns psel in this step
    @(posedge clk);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdv);
  endtask
  task automatic t_regs;
    rd(LIM, 32'hff);
    rd(CNT, 32'h0);
    rd(CTL, 32'h0);
    rd(FLG, 32'h0);
    rd(ENA, 32'h0);
    rd(12'h004, 32'h0);
    chk("pslverr", 1, errv);
    apb(1'b1, CTL, 32'hff);
    rd(CTL, 32'h7f);
    apb(1'b1, CTL, 32'h78);
    apb(1'b1, CNT, 32'h05);
    repeat (40) @(posedge clk);
    rd(CNT, 32'h05);
    apb(1'b1, CTL, 32'h00);
    rd(CNT, 32'h05);
    apb(1'b1, LIM, 32'h03);
    rd(LIM, 32'h03);
    pstrb <= 4'he;
    apb(1'b1, LIM, 32'h55);
    pstrb <= 4'hf;
    rd(LIM, 32'h03);
  endtask
  // Reset with the timer stopped must clear the count and restore the limit
  task automatic t_reset;
    apb(1'b1, CNT, 32'h5a);
    apb(1'b1, ENA, 32'h2);
    chk("pwmCount", 32'h5a, pwmCount);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("pwmCount", 32'h0, pwmCount);
    rd(CNT, 32'h0);
    rd(LIM, 32'hff);
    rd(ENA, 32'h0);
    rd(CTL, 32'h0);
  endtask
  task automatic t_period(logic [1:0] pre, int exp);
    apb(1'b1, CTL, {29'h0, 1'b1, pre});
    do @(posedge clk); while (sspShift !== 1'b1);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (sspShift !== 1'b1);
    chk("period", exp, k);
  endtask
  // Stopping first keeps a stray match from landing between setup writes
  task automatic t_post(logic [3:0] f);
    apb(1'b1, CTL, 32'h0);
    apb(1'b1, FLG, 32'h2);
    apb(1'b1, ENA, 32'h2);
    apb(1'b1, CTL, {25'h0, f, 3'h4});
    k = 0;
    do begin
      @(posedge clk);
      if (sspShift === 1'b1) k++;
    end while (irq !== 1'b1);
    chk("post", f + 1, k);
  endtask
  task automatic t_irq;
    apb(1'b1, CTL, 32'h0);
    apb(1'b1, ENA, 32'h0);
    @(posedge clk);
    chk("irq", 0, irq);
    rd(FLG, 32'h2);
    apb(1'b1, ENA, 32'h2);
    @(posedge clk);
    chk("irq", 1, irq);
    apb(1'b1, FLG, 32'h2);
    @(posedge clk);
    chk("irq", 0, irq);
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs;
    t_period(2'h0, 16);
    t_period(2'h1, 64);
    t_period(2'h2, 256);
    t_period(2'h3, 256);
    t_post(4'h0);
    t_post(4'h1);
    t_post(4'hf);
    t_irq;
    t_reset;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up;
  end
endmodule
bind period_timer period_timer_properties u_chk (.clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .prdata, .irq, .sspShift, .pwmBase, .pwmCount);
